// file: rtl/hssq_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// pump-side startup sequencer: config accept, V.8 run, module requests
// ----------------------------------------------------------------
module hssq_top #(
  parameter int TIMEOUT_CYC = hssq_pkg::DL_TIMEOUT_CYC,
  parameter bit AFE_VARIANT = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        role_server,
  input  wire logic        originate_select,
  input  wire logic        terminal_ready,
  input  wire logic        ram_wr,
  input  wire logic        ram_rd,
  input  wire logic [11:0] ram_addr,
  input  wire logic [7:0]  ram_wdata,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        flag_set,
  input  wire logic        code_clr,
  input  wire logic        adr_wr,
  input  wire logic [15:0] adr_wdata,
  input  wire logic        v8_done,
  input  wire logic [7:0]  v8_code,
  input  wire logic        v8_vfc,
  input  wire logic        far_v90,
  output logic [7:0]       ram_rdata,
  output logic [7:0]       config_code,
  output logic             new_config_flag,
  output logic [7:0]       download_request_code,
  output logic [15:0]      ram_adr_cnt,
  output logic             v8_start,
  output logic             handshake_go,
  output logic             gstn_octet_send,
  output logic             download_abort
);
  import hssq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    hssq_state_t st;
    logic [7:0]  cfg;
    logic        nflag;
    logic [7:0]  code;
    logic [7:0]  pend;
    logic [15:0] adr;
    logic        v8;
    logic        go;
    logic        gstn;
    logic        abort;
    logic [7:0]  rdata;
    logic [7:0]  r304;
    logic [7:0]  r309;
    logic [7:0]  r406;
    logic [7:0]  r409;
    logic [7:0]  r6a2;
    logic [7:0]  r6a3;
  } hssq_regs_t;

  hssq_regs_t q, d;
  logic       tmo_expired;

  // ----------------------------------------------------------------
  // start-address wait timer
  // ----------------------------------------------------------------
  hssq_timer #(
    .CYC (TIMEOUT_CYC)
  ) u_adr_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (q.st == HSSQ_WAIT_ADR),
    .expired (tmo_expired)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.go    = 1'b0;
    d.abort = 1'b0;

    // host writes into dsp ram locations
    if (ram_wr) begin
      if (ram_addr == ADR_GSTN_CTRL) begin
        d.r304 = ram_wdata;
      end else if (ram_addr == ADR_V34_START) begin
        d.r309 = ram_wdata;
      end else if (ram_addr == ADR_PCM_FALLBK) begin
        d.r406 = ram_wdata;
      end else if (ram_addr == ADR_PROP_START) begin
        d.r409 = ram_wdata;
      end else if (ram_addr == ADR_V90_START) begin
        d.r6a2 = ram_wdata;
      end else if (ram_addr == ADR_V90_CAP) begin
        d.r6a3 = ram_wdata;
      end
    end

    // reads of unmapped locations return zero
    if (ram_rd) begin
      if (ram_addr == ADR_GSTN_CTRL) begin
        d.rdata = q.r304;
      end else if (ram_addr == ADR_V34_START) begin
        d.rdata = q.r309;
      end else if (ram_addr == ADR_PCM_FALLBK) begin
        d.rdata = q.r406;
      end else if (ram_addr == ADR_PROP_START) begin
        d.rdata = q.r409;
      end else if (ram_addr == ADR_V90_START) begin
        d.rdata = q.r6a2;
      end else if (ram_addr == ADR_V90_CAP) begin
        d.rdata = q.r6a3;
      end else begin
        d.rdata = RAM_RESET;
      end
    end

    // host may rewrite the configuration code at any time
    if (cfg_wr) begin
      d.cfg = cfg_wdata;
    end

    // octet goes out when enabled, and on an answering server whenever the
    // caller is V.90 capable even though the host left it off
    d.gstn = q.r304[GSTN_BIT] |
             (role_server & ~originate_select & far_v90);

    case (q.st)
      HSSQ_IDLE: begin
        // accept any new configuration; only the V.8 value arms the start
        if (q.nflag) begin
          d.nflag = 1'b0;
          if (q.cfg == CFG_V8) begin
            d.st = HSSQ_ARMED;
          end
        end
      end
      HSSQ_ARMED: begin
        if (terminal_ready) begin
          d.v8 = 1'b1;
          d.st = HSSQ_V8;
        end
      end
      HSSQ_V8: begin
        if (v8_vfc) begin
          // vfc needs its own module before anything else runs
          d.code = REQ_VFC;
          d.adr  = ADR_CNT_PRE;
          d.pend = REQ_NONE;
          d.st   = HSSQ_WAIT_ADR;
        end else if (v8_done) begin
          d.v8  = 1'b0;
          d.cfg = v8_code;
          if (v8_code[7:4] == NIB_V90_E || v8_code[7:4] == NIB_V90_F) begin
            d.adr = ADR_CNT_PRE;
            d.st  = HSSQ_WAIT_ADR;
            if (AFE_VARIANT) begin
              d.code = REQ_V90;
              d.pend = REQ_NONE;
            end else begin
              d.code = REQ_PCM_COMM;
              d.pend = REQ_V90;
            end
          end else if (v8_code[7:4] == NIB_V34 && !AFE_VARIANT) begin
            d.code = REQ_PCM_COMM;
            d.pend = REQ_NONE;
            d.adr  = ADR_CNT_PRE;
            d.st   = HSSQ_WAIT_ADR;
          end else if (v8_code == CFG_PROP && !role_server) begin
            d.st = HSSQ_PROP;
          end else begin
            // modes already resident: analog V.34 and the rest
            d.go = 1'b1;
            d.st = HSSQ_DONE;
          end
        end
      end
      HSSQ_WAIT_ADR: begin
        if (adr_wr) begin
          d.adr = adr_wdata;
          d.st  = HSSQ_LOAD;
        end else if (tmo_expired) begin
          d.code  = REQ_NONE;
          d.abort = 1'b1;
          d.st    = HSSQ_DONE;
        end
      end
      HSSQ_LOAD: begin
        // host zeroes the code after the last byte of the module
        if (code_clr) begin
          if (q.pend != REQ_NONE) begin
            d.code = q.pend;
            d.pend = REQ_NONE;
            d.adr  = ADR_CNT_PRE;
            d.st   = HSSQ_WAIT_ADR;
          end else begin
            d.code = REQ_NONE;
            d.go   = 1'b1;
            d.st   = HSSQ_DONE;
          end
        end
      end
      HSSQ_PROP: begin
        // legacy handshake resumes on the run code, no flag needed
        if (cfg_wr && cfg_wdata == CFG_PROP_RUN) begin
          d.go = 1'b1;
          d.st = HSSQ_DONE;
        end
      end
      HSSQ_DONE: begin
        // a fresh configuration restarts the sequence
        if (q.nflag) begin
          d.st = HSSQ_IDLE;
        end
      end
      default: begin
        d.st = HSSQ_IDLE;
      end
    endcase

    // host setting the flag wins over the pump clearing it
    if (flag_set) begin
      d.nflag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q       <= '0;
      q.st    <= HSSQ_IDLE;
      q.cfg   <= RAM_RESET;
      q.code  <= REQ_NONE;
      q.pend  <= REQ_NONE;
      q.adr   <= ADR_CNT_RESET;
      q.rdata <= RAM_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs come straight from the state register
  assign ram_rdata             = q.rdata;
  assign config_code           = q.cfg;
  assign new_config_flag       = q.nflag;
  assign download_request_code = q.code;
  assign ram_adr_cnt           = q.adr;
  assign v8_start              = q.v8;
  assign handshake_go          = q.go;
  assign gstn_octet_send       = q.gstn;
  assign download_abort        = q.abort;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_flag_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_IDLE && new_config_flag && !flag_set) |=> !new_config_flag)
    else $error("new config flag not cleared by pump");

  a_v8_needs_arm: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(v8_start) |-> $past(q.st) == HSSQ_ARMED && $past(terminal_ready))
    else $error("V.8 started without accepted config and terminal ready");

  a_code_moves: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_V8 && v8_done && !v8_vfc) |=> config_code == $past(v8_code) && !v8_start)
    else $error("config code not updated at end of V.8");

  a_vfc_request: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_V8 && v8_vfc) |=> download_request_code == REQ_VFC)
    else $error("vfc module not requested");

  a_v90_pair: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_V8 && v8_done && !v8_vfc && !AFE_VARIANT &&
     (v8_code[7:4] == NIB_V90_E || v8_code[7:4] == NIB_V90_F))
    |=> download_request_code == REQ_PCM_COMM ##1 q.pend == REQ_V90)
    else $error("V.90 module pair not requested");

  a_afe_v34: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_V8 && v8_done && !v8_vfc && AFE_VARIANT && v8_code[7:4] == NIB_V34)
    |=> download_request_code == REQ_NONE && handshake_go)
    else $error("analog variant requested a module for V.34");

  a_preset_adr: assert property (@(posedge clk) disable iff (sys_rst)
    ($changed(download_request_code) && download_request_code != REQ_NONE)
    |-> ram_adr_cnt == ADR_CNT_PRE)
    else $error("address counter not preset with request");

  a_abort_zero: assert property (@(posedge clk) disable iff (sys_rst)
    download_abort |-> download_request_code == REQ_NONE && $past(q.st) == HSSQ_WAIT_ADR)
    else $error("abort without zeroed request code");

  a_go_after_load: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_LOAD && code_clr && q.pend == REQ_NONE) |=> handshake_go ##1 !handshake_go)
    else $error("handshake not continued after download");

  a_prop_resume: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HSSQ_PROP && cfg_wr && cfg_wdata == CFG_PROP_RUN) |=> handshake_go)
    else $error("legacy handshake not resumed on run code");

  a_gstn_auto: assert property (@(posedge clk) disable iff (sys_rst)
    (role_server && !originate_select && far_v90) |=> gstn_octet_send)
    else $error("octet not sent to V.90 caller");

  c_vfc_load: cover property (@(posedge clk) disable iff (sys_rst)
    download_request_code == REQ_VFC ##[1:50] handshake_go);

  c_abort: cover property (@(posedge clk) disable iff (sys_rst)
    download_abort);

  c_pair_done: cover property (@(posedge clk) disable iff (sys_rst)
    download_request_code == REQ_V90 ##[1:50] handshake_go);

endmodule : hssq_top

// file: rtl/hssq_pkg.sv
// Function
// - answering server clears the GSTN bit; pump still sends it to V.90 clients
// - host sets new config flag, pump clears it, then terminal ready starts V.8
// - VFC negotiated: pump requests the VFC module, host then goes post-connection
// - pump ends V.8 by moving the config code off the V.8 value, then requests modules
// - once requested downloads finish, the pump continues the handshake by itself
// - client: Exh/Fxh requests common PCM and V.90 modules, Cxh only common PCM
// - client code 00h: host loads legacy modules, writes 9Dh, pump continues
// - analog variant: no request for V.34, only the analog PCM module for V.90
// - pump presets address counter to all ones and writes a request code
// - no start address within 30 seconds: pump aborts by zeroing the request code
package hssq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int DL_TIMEOUT_S   = 30;
  localparam int DL_TIMEOUT_CYC = DL_TIMEOUT_S * CLK_HZ;

  // ----------------------------------------------------------------
  // dsp ram locations
  // ----------------------------------------------------------------
  localparam logic [11:0] ADR_GSTN_CTRL  = 12'h304;
  localparam logic [11:0] ADR_V34_START  = 12'h309;
  localparam logic [11:0] ADR_PCM_FALLBK = 12'h406;
  localparam logic [11:0] ADR_PROP_START = 12'h409;
  localparam logic [11:0] ADR_V90_START  = 12'h6a2;
  localparam logic [11:0] ADR_V90_CAP    = 12'h6a3;
  localparam int          GSTN_BIT       = 4;
  localparam logic [7:0]  RAM_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // configuration codes and request codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_V8        = 8'haa;
  localparam logic [7:0]  CFG_PROP      = 8'h00;
  localparam logic [7:0]  CFG_PROP_RUN  = 8'h9d;
  localparam logic [3:0]  NIB_V90_E     = 4'he;
  localparam logic [3:0]  NIB_V90_F     = 4'hf;
  localparam logic [3:0]  NIB_V34       = 4'hc;
  localparam logic [7:0]  REQ_NONE      = 8'h00;
  localparam logic [7:0]  REQ_PCM_COMM  = 8'h43;
  localparam logic [7:0]  REQ_VFC       = 8'h48;
  localparam logic [7:0]  REQ_V90       = 8'h4a;
  localparam logic [15:0] ADR_CNT_PRE   = 16'hffff;
  localparam logic [15:0] ADR_CNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSSQ_IDLE,
    HSSQ_ARMED,
    HSSQ_V8,
    HSSQ_WAIT_ADR,
    HSSQ_LOAD,
    HSSQ_PROP,
    HSSQ_DONE
  } hssq_state_t;

endpackage : hssq_pkg

// file: rtl/hssq_timer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// wait timer: counts while run is high, restarts when run drops
// ----------------------------------------------------------------
module hssq_timer #(
  parameter int CYC = 16,
  parameter int W   = $clog2(CYC + 1)
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      expired
);
  import hssq_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } hssq_tmr_t;

  localparam logic [W-1:0] LAST = W'(CYC - 1);

  hssq_tmr_t q, d;

  // count up to the limit, then an expiry flag that holds until run drops
  always_comb begin
    d = q;
    if (!run) begin
      d.cnt = '0;
      d.exp = 1'b0;
    end else if (q.cnt == LAST) begin
      d.exp = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.exp;

endmodule : hssq_timer

// file: dv/hssq_host.sv
`timescale 1ns/100ps
// ----------------------------------------
// host processor model, pins move on the falling edge
// ----------------------------------------
module hssq_host (
  input  wire logic        clk,
  input  wire logic        new_config_flag,
  input  wire logic [7:0]  download_request_code,
  input  wire logic [7:0]  ram_rdata,
  output logic             originate_select,
  output logic             terminal_ready,
  output logic             ram_wr,
  output logic             ram_rd,
  output logic [11:0]      ram_addr,
  output logic [7:0]       ram_wdata,
  output logic             cfg_wr,
  output logic [7:0]       cfg_wdata,
  output logic             flag_set,
  output logic             code_clr,
  output logic             adr_wr,
  output logic [15:0]      adr_wdata
);
  import hssq_pkg::*;

  // idle: strobes low; released data shows the inverse of its last value
  initial begin
    {originate_select, terminal_ready, ram_wr, ram_rd} = 4'h0;
    {cfg_wr, flag_set, code_clr, adr_wr} = 4'h0;
    ram_addr  = 12'h000;
    ram_wdata = 8'h00;
    cfg_wdata = 8'h00;
    adr_wdata = 16'h0000;
  end

  task automatic ram_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    ram_addr  = a;
    ram_wdata = d;
    ram_wr    = 1'b1;
    @(negedge clk);
    ram_wr    = 1'b0;
    ram_wdata = ~d;
  endtask : ram_write

  task automatic ram_read(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    ram_addr = a;
    ram_rd   = 1'b1;
    @(negedge clk);
    ram_rd   = 1'b0;
    d        = ram_rdata;
  endtask : ram_read

  task automatic cfg_write(input logic [7:0] d);
    @(negedge clk);
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(negedge clk);
    cfg_wr    = 1'b0;
    cfg_wdata = ~d;
  endtask : cfg_write

  task automatic set_flag();
    @(negedge clk);
    flag_set = 1'b1;
    @(negedge clk);
    flag_set = 1'b0;
  endtask : set_flag

  task automatic set_dtr(input logic v);
    @(negedge clk);
    terminal_ready = v;
  endtask : set_dtr

  task automatic give_adr(input logic [15:0] a);
    @(negedge clk);
    adr_wdata = a;
    adr_wr    = 1'b1;
    @(negedge clk);
    adr_wr    = 1'b0;
    adr_wdata = ~a;
  endtask : give_adr

  // module end: the host zeroes the request code after the last byte
  task automatic end_module();
    @(negedge clk);
    code_clr = 1'b1;
    @(negedge clk);
    code_clr = 1'b0;
  endtask : end_module

  // setup writes before the start, server or client flavour
  // startup loads and the V.8bis exchange come before this
  task automatic setup(input logic srv, input logic orig);
    @(negedge clk);
    originate_select = orig;
    if (srv) begin
      ram_write(ADR_V90_CAP, 8'h6b);
      ram_write(ADR_PCM_FALLBK, 8'h01);
      ram_write(ADR_GSTN_CTRL, orig ? 8'h10 : 8'h00);
    end else begin
      ram_write(ADR_V90_CAP, 8'h05);
      ram_write(ADR_PROP_START, 8'h00);
      ram_write(ADR_GSTN_CTRL, 8'h10);
    end
    ram_write(ADR_V90_START, 8'he3);
    ram_write(ADR_V34_START, 8'hc5);
  endtask : setup

  // alternate fallback: capability bit 6 cleared, bit 5 set, fallback bit on
  task automatic alt_fallback();
    ram_write(ADR_V90_CAP, 8'h2b);
    ram_write(ADR_PCM_FALLBK, 8'h01);
  endtask : alt_fallback

  // waits on the pump are bounded so a dead pump cannot hang the host
  task automatic wait_flag_clear(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(negedge clk);
      ok = (new_config_flag === 1'b0);
    end
  endtask : wait_flag_clear

  task automatic wait_req(output bit ok);
    ok = (download_request_code !== REQ_NONE);
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge clk);
      ok = (download_request_code !== REQ_NONE);
    end
  endtask : wait_req
endmodule : hssq_host

// file: dv/hssq_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
  import hssq_pkg::*;
  localparam int TO = 20;
  int   n_fail = 0, n_compared = 0;
  logic clk, sys_rst, role_server, v8_done, v8_vfc, far_v90;
  logic originate_select, terminal_ready, ram_wr, ram_rd, cfg_wr, flag_set, code_clr, adr_wr;
  logic [7:0]  afe_code;
  logic        afe_go;
  logic new_config_flag, v8_start, handshake_go, gstn_octet_send, download_abort;
  logic [7:0]  v8_code, ram_wdata, cfg_wdata, ram_rdata, config_code, download_request_code;
  logic [11:0] ram_addr;
  logic [15:0] adr_wdata, ram_adr_cnt;

  hssq_top #(.TIMEOUT_CYC(TO), .AFE_VARIANT(1'b0)) i_hssq_top (
    .clk, .sys_rst, .role_server, .originate_select, .terminal_ready, .ram_wr, .ram_rd,
    .ram_addr, .ram_wdata, .cfg_wr, .cfg_wdata, .flag_set, .code_clr, .adr_wr, .adr_wdata,
    .v8_done, .v8_code, .v8_vfc, .far_v90, .ram_rdata, .config_code, .new_config_flag,
    .download_request_code, .ram_adr_cnt, .v8_start, .handshake_go, .gstn_octet_send,
    .download_abort);

  // analog variant pump on the same pins, so its own request rules get exercised
  hssq_top #(.TIMEOUT_CYC(TO), .AFE_VARIANT(1'b1)) i_hssq_top_afe (
    .clk, .sys_rst, .role_server, .originate_select, .terminal_ready, .ram_wr, .ram_rd,
    .ram_addr, .ram_wdata, .cfg_wr, .cfg_wdata, .flag_set, .code_clr, .adr_wr, .adr_wdata,
    .v8_done, .v8_code, .v8_vfc, .far_v90, .ram_rdata (), .config_code (),
    .new_config_flag (), .download_request_code (afe_code), .ram_adr_cnt (), .v8_start (),
    .handshake_go (afe_go), .gstn_octet_send (), .download_abort ());

  hssq_host i_hssq_host (
    .clk, .new_config_flag, .download_request_code, .ram_rdata, .originate_select,
    .terminal_ready, .ram_wr, .ram_rd, .ram_addr, .ram_wdata, .cfg_wr, .cfg_wdata,
    .flag_set, .code_clr, .adr_wr, .adr_wdata);

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // watchdog sized well above the ~400 cycles the tests take
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    test_done();
  end

  // ----------------------------------------
  // shared steps
  // ----------------------------------------
  task automatic do_reset(input logic srv);
    i_hssq_host.set_dtr(1'b0);
    sys_rst     = 1'b1;
    role_server = srv;
    far_v90     = 1'b0;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
  endtask : do_reset

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_hssq_host.ram_read(a, d);
    `CHK(d, e)
  endtask : rd_chk

  // setup, config handshake, then terminal ready starts the negotiation
  task automatic arm(input logic srv, input logic orig);
    bit ok;
    do_reset(srv);
    i_hssq_host.setup(srv, orig);
    i_hssq_host.cfg_write(CFG_V8);
    `CHK(config_code, CFG_V8)
    i_hssq_host.set_flag();
    `CHK(new_config_flag, 1'b1)
    i_hssq_host.wait_flag_clear(ok);
    `CHK(ok, 1'b1)
    `CHK(v8_start, 1'b0)
    i_hssq_host.set_dtr(1'b1);
    @(negedge clk);
    `CHK(v8_start, 1'b1)
  endtask : arm

  task automatic negotiate(input logic [7:0] code);
    @(negedge clk);
    v8_done = 1'b1;
    v8_code = code;
    @(negedge clk);
    v8_done = 1'b0;
    v8_code = ~code;
    `CHK(config_code, code)
    `CHK(v8_start, 1'b0)
  endtask : negotiate

  task automatic serve(input logic [7:0] exp, input logic [15:0] adr);
    bit ok;
    i_hssq_host.wait_req(ok);
    `CHK(download_request_code, exp)
    `CHK(ram_adr_cnt, ADR_CNT_PRE)
    i_hssq_host.give_adr(adr);
    `CHK(ram_adr_cnt, adr)
    i_hssq_host.end_module();
  endtask : serve

  // the pump carries on alone: one go pulse, no request left
  task automatic expect_go();
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      seen = (handshake_go === 1'b1);
      if (!seen) @(negedge clk);
    end
    `CHK(seen, 1'b1)
    `CHK(download_request_code, REQ_NONE)
    @(negedge clk);
    `CHK(handshake_go, 1'b0)
  endtask : expect_go

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [11:0] adrs [6];
    adrs = '{ADR_GSTN_CTRL, ADR_V34_START, ADR_PCM_FALLBK, ADR_PROP_START, ADR_V90_START,
             ADR_V90_CAP};
    do_reset(1'b0);
    `CHK({config_code, new_config_flag, download_request_code, ram_adr_cnt, v8_start,
          handshake_go, download_abort, gstn_octet_send}, 37'h0)
    foreach (adrs[i]) rd_chk(adrs[i], RAM_RESET);
    i_hssq_host.ram_write(12'h123, 8'h5a);
    rd_chk(12'h123, 8'h00);
  endtask : t_regs

  task automatic t_server();
    arm(1'b1, 1'b0);
    rd_chk(ADR_V90_CAP, 8'h6b);
    rd_chk(ADR_PCM_FALLBK, 8'h01);
    rd_chk(ADR_GSTN_CTRL, 8'h00);
    rd_chk(ADR_V90_START, 8'he3);
    rd_chk(ADR_V34_START, 8'hc5);
    repeat (2) @(negedge clk);
    `CHK(gstn_octet_send, 1'b0)
    far_v90 = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(gstn_octet_send, 1'b1)
    negotiate(8'he3);
    serve(REQ_PCM_COMM, 16'h1200);
    serve(REQ_V90, 16'h3400);
    expect_go();
  endtask : t_server

  task automatic t_client(input logic orig, input logic [7:0] code);
    arm(1'b0, orig);
    rd_chk(ADR_V90_CAP, 8'h05);
    rd_chk(ADR_PROP_START, 8'h00);
    `CHK(gstn_octet_send, 1'b1)
    negotiate(code);
    `CHK(afe_code, (code[7:4] == NIB_V34) ? REQ_NONE : REQ_V90)
    `CHK(afe_go, code[7:4] == NIB_V34)
    serve(REQ_PCM_COMM, 16'h0100);
    if (code[7:4] != NIB_V34) serve(REQ_V90, 16'h0800);
    expect_go();
  endtask : t_client

  task automatic t_prop();
    arm(1'b0, 1'b1);
    negotiate(CFG_PROP);
    repeat (4) @(negedge clk);
    `CHK(download_request_code, REQ_NONE)
    `CHK(handshake_go, 1'b0)
    i_hssq_host.cfg_write(CFG_PROP_RUN);
    `CHK(config_code, CFG_PROP_RUN)
    expect_go();
  endtask : t_prop

  task automatic t_vfc();
    arm(1'b1, 1'b1);
    i_hssq_host.alt_fallback();
    rd_chk(ADR_V90_CAP, 8'h2b);
    @(negedge clk);
    v8_vfc = 1'b1;
    @(negedge clk);
    v8_vfc = 1'b0;
    serve(REQ_VFC, 16'h5600);
    expect_go();
  endtask : t_vfc

  // host never supplies a start address: the pump gives up on its own
  task automatic t_timeout();
    bit ok;
    int n;
    arm(1'b0, 1'b0);
    negotiate(8'hc1);
    i_hssq_host.wait_req(ok);
    `CHK(download_request_code, REQ_PCM_COMM)
    n = 0;
    while (download_abort !== 1'b1 && n < 2 * TO) begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= TO - 1 && n <= TO + 3, 1'b1)
    @(negedge clk);
    `CHK(download_request_code, REQ_NONE)
    `CHK(download_abort, 1'b0)
    // a fresh configuration after the abort restarts the sequence
    i_hssq_host.cfg_write(CFG_V8);
    i_hssq_host.set_flag();
    i_hssq_host.wait_flag_clear(ok);
    `CHK(ok, 1'b1)
    @(negedge clk);
    `CHK(v8_start, 1'b1)
  endtask : t_timeout

  // resident modes need no download: the pump carries on at once
  task automatic t_resident();
    arm(1'b1, 1'b0);
    negotiate(8'h84);
    `CHK(download_request_code, REQ_NONE)
    expect_go();
  endtask : t_resident

  initial begin
    {sys_rst, role_server, v8_done, v8_vfc, far_v90} = 5'h10;
    v8_code = 8'h00;
    t_regs();
    t_server();
    t_client(1'b1, 8'hf2);
    t_client(1'b0, 8'hc7);
    t_prop();
    t_vfc();
    t_resident();
    t_timeout();
    test_done();
  end
endmodule : tb_top
